// *** verilog/rbp_port.sv ***
// RS-232 bit-bang port: output latch and gated input port; the synced role plug changes no output.
`timescale 1ns/1ns
module rbp_port #(
  parameter logic [7:0] PORT_ADDR = rbp_pkg::PORT_ADDR_RST
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // Backplane I/O bus
  input wire logic [7:0] addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // Role plug and line pins
  input wire logic role_select_plug_i,
  input wire logic [3:0] line_rx_i,
  input wire logic cable_intlk_n_i,
  // Both roles: pins for each signal pair
  output logic txd_rxd_o,
  output logic rts_cts_o,
  output logic secondary_transmit_line_o,
  output logic dtr_dsr_o
);
  logic [3:0] latch_ff;
  logic [3:0] rx_s1_ff;
  logic [3:0] rx_s2_ff;
  logic [1:0] intlk_ff;
  logic [1:0] role_ff;
  logic [7:0] data_ff;
  logic oe_ff;
  logic [3:0] drv_ff;
  logic [3:0] nxt_rd;
  logic sel;

  // Card decode on bits 7..1, even address picks this port pair.
  assign sel = (addr_i[7:1] == PORT_ADDR[7:1]) && !addr_i[0];

  // Pins from outside pass two flip-flops before use.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_s1_ff <= 4'h0000;
      rx_s2_ff <= 4'h0000;
      intlk_ff <= 2'h0;
      role_ff <= 2'h0;
    end else if (clk_en_i) begin
      rx_s1_ff <= line_rx_i;
      rx_s2_ff <= rx_s1_ff;
      intlk_ff <= {intlk_ff[0], cable_intlk_n_i};
      role_ff <= {role_ff[0], role_select_plug_i};
    end
  end

  // The latch resets to LATCH_RST; the input path's sync flops are reset in the block above.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      latch_ff <= rbp_pkg::LATCH_RST;
    end else if (clk_en_i && io_wr_i && sel) begin
      latch_ff <= data_i[3:0];
    end
  end

  // Interlock grounded by the cable reads as one in the spare receiver bit.
  always_comb begin
    nxt_rd = rx_s2_ff;
    nxt_rd[rbp_pkg::BIT_INTLK] = rx_s2_ff[rbp_pkg::BIT_INTLK] | ~intlk_ff[1];
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      data_ff <= 8'h0000;
      oe_ff <= 1'b0;
    end else if (clk_en_i) begin
      oe_ff <= io_rd_i && sel;
      data_ff <= (io_rd_i && sel) ? {rbp_pkg::UPPER_READ, nxt_rd} : 8'h0000;
    end
  end

  // Both roles drive the same latch bits; the plug does not change which pins
  // carry them, so the pin per bit is the signal pair name. One flop per
  // line keeps each driver independent, as software times every line on
  // its own.
  for (genvar b = 0; b < rbp_pkg::LINE_W; b++) begin : gen_drv
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        drv_ff[b] <= rbp_pkg::LATCH_RST[b];
      end else if (clk_en_i) begin
        drv_ff[b] <= latch_ff[b];
      end
    end
  end

  assign data_o = data_ff;
  assign data_oe_o = oe_ff;
  assign txd_rxd_o = drv_ff[rbp_pkg::BIT_TXD];
  assign rts_cts_o = drv_ff[rbp_pkg::BIT_RTS];
  assign secondary_transmit_line_o = drv_ff[rbp_pkg::BIT_SEC];
  assign dtr_dsr_o = drv_ff[rbp_pkg::BIT_DTR];

  // Software is trusted for bit timing; no rate checking here.

  write_loads_a: assert property (@(posedge clock_i) disable iff (rst_i)
    clk_en_i && io_wr_i && sel |=> latch_ff == $past(data_i[3:0]))
    else $error("latch missed write");
  read_gates_a: assert property (@(posedge clock_i) disable iff (rst_i)
    clk_en_i |=> data_oe_o == $past(io_rd_i && sel))
    else $error("bus enable wrong");
  upper_ones_a: assert property (@(posedge clock_i) disable iff (rst_i)
    data_oe_o |-> data_o[7:4] == rbp_pkg::UPPER_READ)
    else $error("upper nibble not ones");
  odd_ignored_a: assert property (@(posedge clock_i) disable iff (rst_i)
    clk_en_i && addr_i[0] |=> !data_oe_o)
    else $error("odd address answered");
  latch_holds_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !(io_wr_i && sel) |=> $stable(latch_ff))
    else $error("latch changed without write");
  reset_clear_a: assert property (@(posedge clock_i)
    rst_i |=> latch_ff == rbp_pkg::LATCH_RST ##1 drv_ff == rbp_pkg::LATCH_RST)
    else $error("reset did not clear");
  pins_follow_a: assert property (@(posedge clock_i) disable iff (rst_i)
    clk_en_i |=> drv_ff == $past(latch_ff))
    else $error("drivers lag latch");
  idle_zero_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !data_oe_o |-> data_o == 8'h0000)
    else $error("data driven while idle");

  // Freeze, sync and decode paths are reached by the bench only at a few
  // points, so they are pinned down here cycle by cycle.
  freeze_latch_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    !clk_en_i |=> $stable(latch_ff))
    else $error("latch moved while frozen");

  freeze_bus_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    !clk_en_i |=> $stable(data_o) && $stable(data_oe_o))
    else $error("bus moved while frozen");

  freeze_pins_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    !clk_en_i |=> $stable(drv_ff))
    else $error("drivers moved while frozen");

  read_data_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    clk_en_i && io_rd_i && sel |=>
      data_o[3:0] == ($past(rx_s2_ff) | {1'b0, ~$past(intlk_ff[1]), 2'b00}))
    else $error("read data not receivers");

  intlk_bit_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    clk_en_i && io_rd_i && sel && !intlk_ff[1] |=> data_o[rbp_pkg::BIT_INTLK])
    else $error("cable not reported");

  no_cable_bit_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    clk_en_i && io_rd_i && sel && intlk_ff[1] |=>
      data_o[rbp_pkg::BIT_INTLK] == $past(rx_s2_ff[rbp_pkg::BIT_INTLK]))
    else $error("interlock bit forced");

  sync_chain_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    clk_en_i |=> rx_s2_ff == $past(rx_s1_ff))
    else $error("receiver sync broken");

  role_sync_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    clk_en_i |=> role_ff[1] == $past(role_ff[0]))
    else $error("role sync broken");

  intlk_sync_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    clk_en_i |=> intlk_ff[1] == $past(intlk_ff[0]))
    else $error("interlock sync broken");

  card_decode_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    clk_en_i && io_rd_i && (addr_i[7:1] != PORT_ADDR[7:1]) |=> !data_oe_o)
    else $error("other card answered");

  reset_idle_a: assert property (
    @(posedge clock_i)
    rst_i |=> !data_oe_o && data_o == 8'h0000)
    else $error("bus busy after reset");

  no_read_idle_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    clk_en_i && !io_rd_i |=> !data_oe_o)
    else $error("bus driven without read");

  pins_reach_a: assert property (
    @(posedge clock_i) disable iff (rst_i)
    clk_en_i && io_wr_i && sel ##1 clk_en_i |=> drv_ff == $past(data_i[3:0], 2))
    else $error("write did not reach pins");
  wr_cov: cover property (@(posedge clock_i) io_wr_i && sel ##2 txd_rxd_o);
  rd_cov: cover property (@(posedge clock_i) io_rd_i && sel ##1 data_oe_o);
  intlk_cov: cover property (@(posedge clock_i) data_oe_o && data_o[2]);

  // One write cover per plug position, so both roles are seen.
  term_cov: cover property (
    @(posedge clock_i) role_ff[1] == rbp_pkg::ROLE_TERMINAL && io_wr_i && sel);
  set_cov: cover property (
    @(posedge clock_i) role_ff[1] == rbp_pkg::ROLE_SET && io_wr_i && sel);
endmodule

// *** verilog/rbp_pkg.sv ***
// Package of constants for the RS-232 bit-bang I/O port.
package rbp_pkg;
  localparam logic [7:0] PORT_ADDR_RST = 8'h00_C0;
  localparam int LINE_W = 4;
  localparam logic [3:0] UPPER_READ = 4'h000F;
  localparam logic [3:0] LATCH_RST = 4'h0000;
  localparam int BIT_TXD = 0;
  localparam int BIT_RTS = 1;
  localparam int BIT_SEC = 2;
  localparam int BIT_DTR = 3;
  localparam int BIT_INTLK = 2;
  localparam logic ROLE_TERMINAL = 1'b0;
  localparam logic ROLE_SET = 1'b1;
endpackage

// *** test/rbp_host.sv ***
// Processor-side bus master model for the port.
`timescale 1ns/1ns
module rbp_host (
  // Clock
  input wire logic clock_i,
  // Backplane bus
  output logic [7:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] dat_o
);
  initial {rd_o, wr_o, addr_o, dat_o} = 18'h0_0000;
  // Software paces and converts every bit, one access per call.
  task automatic acc(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    {rd_o, wr_o, addr_o, dat_o} <= {r, w, a, d};
    @(posedge clock_i);
    // A released bus shows no stale value.
    {rd_o, wr_o, addr_o, dat_o} <= {2'b00, ~a, ~d};
  endtask
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the RS-232 bit-bang port.
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module testbench;
  logic clock_i = 0, rst_i, clk_en_i, role_select_plug_i, cable_intlk_n_i;
  logic [3:0] line_rx_i;
  logic [7:0] addr_i, data_i, data_o;
  logic io_rd_i, io_wr_i, data_oe_o, txd_rxd_o, rts_cts_o, secondary_transmit_line_o, dtr_dsr_o;
  wire [3:0] pins = {dtr_dsr_o, secondary_transmit_line_o, rts_cts_o, txd_rxd_o};
  int errors = 0, compares = 0, cyc = 0;
  logic [31:0] r;
  // Row: role, write data, receivers, interlock_n, expected read, expected pins.
  logic [31:0] rows [4] = '{32'h0a53_1f35, 32'h10ac_1fca, 32'h0ff0_0f4f, 32'h130a_0fe0};
  rbp_host rbp_host_i (.clock_i, .addr_o(addr_i), .rd_o(io_rd_i), .wr_o(io_wr_i), .dat_o(data_i));
  rbp_port rbp_port_i (.clock_i, .rst_i, .clk_en_i, .addr_i, .io_rd_i, .io_wr_i, .data_i,
    .data_o, .data_oe_o, .role_select_plug_i, .line_rx_i, .cable_intlk_n_i, .txd_rxd_o,
    .rts_cts_o, .secondary_transmit_line_o, .dtr_dsr_o);
  always #4 clock_i = ~clock_i;
  task results;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Whole run needs about 50 cycles.
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      results;
    end
  end
  initial begin
    {rst_i, clk_en_i, role_select_plug_i, line_rx_i, cable_intlk_n_i} = 8'h00C1;
    repeat (6) @(posedge clock_i);
    rst_i <= 0;
    #1 `CHK(pins, 4'h0)
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      @(posedge clock_i);
      {role_select_plug_i, line_rx_i, cable_intlk_n_i} <= {r[28], r[19:16], r[12]};
      rbp_host_i.acc(0, 1, 8'h00c0, r[27:20]);
      @(posedge clock_i);
      #1 `CHK(pins, r[3:0])
      rbp_host_i.acc(1, 0, 8'h00c0, 8'h0000);
      #1 `CHK({data_oe_o, data_o}, {1'b1, r[11:4]})
    end
    rbp_host_i.acc(0, 1, 8'h00c1, 8'h000f);
    rbp_host_i.acc(0, 1, 8'h00c2, 8'h000f);
    @(posedge clock_i);
    clk_en_i <= 0;
    rbp_host_i.acc(0, 1, 8'h00c0, 8'h000f);
    clk_en_i <= 1;
    rbp_host_i.acc(1, 0, 8'h00c1, 8'h0000);
    #1 `CHK({data_oe_o, pins}, 5'h00)
    rbp_host_i.acc(0, 1, 8'h00c0, 8'h000f);
    @(posedge clock_i);
    #1 `CHK(pins, 4'hf)
    @(posedge clock_i);
    rst_i <= 1;
    repeat (3) @(posedge clock_i);
    rst_i <= 0;
    #1 `CHK(pins, 4'h0)
    repeat (3) @(posedge clock_i);
    rbp_host_i.acc(1, 0, 8'h00c0, 8'h0000);
    #1 `CHK(data_o, 8'hfe)
    results;
  end
endmodule
